/* File: hw/lstm_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef LSTM_MAP_SVH
`define LSTM_MAP_SVH
`define LSTM_CTRL          12'h000
`define LSTM_TX_MIN_LEN    12'h004
`define LSTM_RISE_THR      12'h008
`define LSTM_FALL_THR      12'h00C
`define LSTM_PERIOD        12'h010
`define LSTM_MON_STATUS    12'h014
`define LSTM_MEASURED      12'h018
`define LSTM_CNT_HIGH      12'h020
`define LSTM_CNT_BASE      12'h100
`define LSTM_CTRL_SEL_LO   0
`define LSTM_CTRL_SEL_HI   4
`define LSTM_CTRL_TYPE_LO  5
`define LSTM_CTRL_TYPE_HI  6
`define LSTM_CTRL_ABS      7
`define LSTM_CTRL_EN       8
`define LSTM_ST_RISE       0
`define LSTM_ST_FALL       1
`define LSTM_ST_RARM       2
`define LSTM_ST_FARM       3
`define LSTM_TX_MIN_RST    16'h0040
`define LSTM_MAX_STD_LEN   16'h05EE
`define LSTM_PERIOD_RST    16'h000F
`define LSTM_CLK_NS        25
`define LSTM_SECOND_NS     1000000000
`define LSTM_SECOND_CYC    (`LSTM_SECOND_NS / `LSTM_CLK_NS)
`endif

/* File: hw/lstm_pkg.sv */
// Types shared by the statistics and threshold monitor
package lstm_pkg;
   typedef struct packed {
      logic        frameDone;
      logic [15:0] octets;
      logic        fcsBad;
      logic        wellFormed;
      logic        codeWord;
      logic        lineCodeViol;
      logic        hdlcCrcErr;
   } lstm_rx_t;
   typedef struct packed {
      logic        frameDone;
      logic [15:0] octets;
      logic        codeWord;
      logic        lineCodeViol;
      logic        hdlcCrcErr;
   } lstm_tx_t;
   typedef struct packed {
      logic frameCrcErr;
      logic superblockCrcErr;
      logic clientFail;
      logic coreHeaderErr;
      logic typeHeaderErr;
      logic inFrame;
   } lstm_gfp_t;
   typedef enum logic [1:0] {
      LSTM_ALARM_OFF     = 2'h0,
      LSTM_ALARM_RISING  = 2'h1,
      LSTM_ALARM_FALLING = 2'h2,
      LSTM_ALARM_BOTH    = 2'h3
   } lstm_alarm_t;
endpackage

/* File: hw/link_stats_monitor.sv */
// Link statistics counters with one threshold alarm monitor, APB slave
`timescale 1ns/1ps
`include "lstm_map.svh"

module link_stats_monitor #(
   parameter int          NCNT      = 18,
   parameter int          CNT_W     = 48,
   parameter logic [31:0] TICKS_SEC = 32'(`LSTM_SECOND_CYC)
) (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr,
   input  wire lstm_pkg::lstm_rx_t  rxEv,
   input  wire lstm_pkg::lstm_tx_t  txEv,
   input  wire lstm_pkg::lstm_gfp_t gfpEv,
   output logic                    risingEvent,
   output logic                    fallingEvent
);
   logic [CNT_W-1:0] cnt    [NCNT];
   logic [15:0]      incAmt [NCNT];
   logic [15:0]      txMinLen;
   logic [31:0]      riseThr;
   logic [31:0]      fallThr;
   logic [15:0]      periodSec;
   logic [8:0]       ctrl;
   logic [31:0]      cntHigh;
   logic             riseFlag;
   logic             fallFlag;
   logic             riseArmed;
   logic             fallArmed;
   logic [31:0]      measVal;
   logic [31:0]      snap;
   logic [31:0]      tickCnt;
   logic [15:0]      secCnt;
   logic             inFramePrev;
   logic             setup;
   logic             wrEn;
   logic [4:0]       cntIdx;
   logic             cntHit;
   logic [31:0]      selLow;
   logic [31:0]      next_meas;
   logic             periodEnd;
   logic             eval;
   logic             rxLong;
   logic             allowRise;
   logic             allowFall;
   lstm_pkg::lstm_alarm_t alarmType;

   assign setup     = psel & ~penable;
   assign wrEn      = psel & penable & pready & pwrite;
   assign cntIdx    = paddr[6:2];
   assign cntHit    = (paddr[11:7] == 5'(`LSTM_CNT_BASE >> 7)) && (int'(cntIdx) < NCNT);
   assign alarmType = lstm_pkg::lstm_alarm_t'(ctrl[`LSTM_CTRL_TYPE_HI:`LSTM_CTRL_TYPE_LO]);
   assign allowRise = alarmType == lstm_pkg::LSTM_ALARM_RISING || alarmType == lstm_pkg::LSTM_ALARM_BOTH;
   assign allowFall = alarmType == lstm_pkg::LSTM_ALARM_FALLING || alarmType == lstm_pkg::LSTM_ALARM_BOTH;
   assign rxLong    = rxEv.frameDone && rxEv.octets > `LSTM_MAX_STD_LEN;

   // Per-counter increment for this cycle
   always_comb begin
      incAmt[0]  = {15'h0000, rxLong & rxEv.wellFormed & ~rxEv.fcsBad};
      incAmt[1]  = {15'h0000, rxLong & rxEv.fcsBad};
      incAmt[2]  = rxEv.frameDone ? rxEv.octets : 16'h0000;
      incAmt[3]  = {15'h0000, txEv.frameDone && txEv.octets < txMinLen};
      incAmt[4]  = {15'h0000, rxEv.frameDone};
      incAmt[5]  = {15'h0000, txEv.frameDone};
      incAmt[6]  = {15'h0000, rxEv.hdlcCrcErr};
      incAmt[7]  = {15'h0000, txEv.hdlcCrcErr};
      incAmt[8]  = {15'h0000, rxEv.lineCodeViol};
      incAmt[9]  = {15'h0000, txEv.lineCodeViol};
      incAmt[10] = {15'h0000, rxEv.codeWord};
      incAmt[11] = {15'h0000, txEv.codeWord};
      incAmt[12] = {15'h0000, gfpEv.frameCrcErr};
      incAmt[13] = {15'h0000, gfpEv.superblockCrcErr};
      incAmt[14] = {15'h0000, gfpEv.clientFail};
      incAmt[15] = {15'h0000, inFramePrev & ~gfpEv.inFrame};
      incAmt[16] = {15'h0000, gfpEv.coreHeaderErr};
      incAmt[17] = {15'h0000, gfpEv.typeHeaderErr};
   end

   for (genvar i = 0; i < NCNT; i++) begin : g_cnt
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            cnt[i] <= '0;
         end else begin
            cnt[i] <= cnt[i] + CNT_W'(incAmt[i]);
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         inFramePrev <= 1'b0;
      end else begin
         inFramePrev <= gfpEv.inFrame;
      end
   end

   // Software settings
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl      <= 9'h000;
         txMinLen  <= `LSTM_TX_MIN_RST;
         riseThr   <= 32'h00000000;
         fallThr   <= 32'h00000000;
         periodSec <= `LSTM_PERIOD_RST;
      end else if (wrEn) begin
         unique case (paddr)
            `LSTM_CTRL:       ctrl      <= pwdata[8:0];
            `LSTM_TX_MIN_LEN: txMinLen  <= pwdata[15:0];
            `LSTM_RISE_THR:   riseThr   <= pwdata;
            `LSTM_FALL_THR:   fallThr   <= pwdata;
            `LSTM_PERIOD:     periodSec <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // APB answer prepared in setup, presented in the access phase
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
         if (setup) begin
            unique case (paddr)
               `LSTM_CTRL:       prdata <= {23'h000000, ctrl};
               `LSTM_TX_MIN_LEN: prdata <= {16'h0000, txMinLen};
               `LSTM_RISE_THR:   prdata <= riseThr;
               `LSTM_FALL_THR:   prdata <= fallThr;
               `LSTM_PERIOD:     prdata <= {16'h0000, periodSec};
               `LSTM_MON_STATUS: prdata <= {28'h0000000, fallArmed, riseArmed, fallFlag, riseFlag};
               `LSTM_MEASURED:   prdata <= measVal;
               `LSTM_CNT_HIGH:   prdata <= cntHigh;
               default: begin
                  if (cntHit && !pwrite) begin
                     prdata <= cnt[cntIdx][31:0];
                  end else begin
                     pslverr <= ~cntHit;
                  end
               end
            endcase
         end
      end
   end

   // High word frozen in the same cycle the low word is sampled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cntHigh <= 32'h00000000;
      end else if (setup && !pwrite && cntHit) begin
         cntHigh <= 32'(cnt[cntIdx][CNT_W-1:32]);
      end
   end

   // Seconds and sample period timing
   assign periodEnd = tickCnt == TICKS_SEC - 32'h00000001
                      && secCnt + 16'h0001 >= periodSec;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tickCnt <= 32'h00000000;
         secCnt  <= 16'h0000;
      end else if (tickCnt == TICKS_SEC - 32'h00000001) begin
         tickCnt <= 32'h00000000;
         secCnt  <= periodEnd ? 16'h0000 : secCnt + 16'h0001;
      end else begin
         tickCnt <= tickCnt + 32'h00000001;
      end
   end

   assign selLow    = cnt[ctrl[`LSTM_CTRL_SEL_HI:`LSTM_CTRL_SEL_LO]][31:0];
   assign next_meas = ctrl[`LSTM_CTRL_ABS] ? selLow : selLow - snap;
   assign eval      = ctrl[`LSTM_CTRL_EN] && (ctrl[`LSTM_CTRL_ABS] || periodEnd);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         snap    <= 32'h00000000;
         measVal <= 32'h00000000;
      end else begin
         if (periodEnd) begin
            snap <= selLow;
         end
         if (eval) begin
            measVal <= next_meas;
         end
      end
   end

   // Hysteresis: each direction fires once, armed by the opposite threshold
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         riseArmed    <= 1'b1;
         fallArmed    <= 1'b0;
         risingEvent  <= 1'b0;
         fallingEvent <= 1'b0;
      end else begin
         risingEvent  <= 1'b0;
         fallingEvent <= 1'b0;
         if (eval) begin
            if (riseArmed && next_meas > riseThr) begin
               riseArmed   <= 1'b0;
               risingEvent <= allowRise;
            end else if (next_meas < fallThr) begin
               riseArmed <= 1'b1;
            end
            if (fallArmed && next_meas < fallThr) begin
               fallArmed    <= 1'b0;
               fallingEvent <= allowFall;
            end else if (next_meas > riseThr) begin
               fallArmed <= 1'b1;
            end
         end
      end
   end

   // Sticky flags, write one to clear; a new event wins over the clear
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         riseFlag <= 1'b0;
         fallFlag <= 1'b0;
      end else begin
         riseFlag <= risingEvent
                     | (riseFlag & ~(wrEn && paddr == `LSTM_MON_STATUS && pwdata[`LSTM_ST_RISE]));
         fallFlag <= fallingEvent
                     | (fallFlag & ~(wrEn && paddr == `LSTM_MON_STATUS && pwdata[`LSTM_ST_FALL]));
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_periodClose;
      periodEnd && ctrl[`LSTM_CTRL_EN] && !ctrl[`LSTM_CTRL_ABS];
   endsequence
   sequence s_riseFire;
      eval && riseArmed && next_meas > riseThr && allowRise;
   endsequence

   chk_oversize_count: assert property (rxLong && rxEv.wellFormed && !rxEv.fcsBad
      |=> cnt[0] == $past(cnt[0]) + CNT_W'(1)) else $error("oversize count missed");
   chk_long_badfcs: assert property (rxLong && rxEv.fcsBad
      |=> cnt[1] == $past(cnt[1]) + CNT_W'(1)) else $error("long bad FCS count missed");
   chk_octet_add: assert property (rxEv.frameDone
      |=> cnt[2] == $past(cnt[2]) + CNT_W'($past(rxEv.octets))) else $error("octet total wrong");
   chk_tx_short: assert property (txEv.frameDone && txEv.octets >= txMinLen
      |=> cnt[3] == $past(cnt[3])) else $error("short tx counted wrongly");
   chk_delin_loss: assert property ($fell(gfpEv.inFrame)
      |=> cnt[15] == $past(cnt[15]) + CNT_W'(1)) else $error("loss of frame not counted");
   chk_rel_window: assert property (s_periodClose
      |=> measVal == $past(selLow) - $past(snap) && snap == $past(selLow))
      else $error("relative sample wrong");
   chk_rise_once: assert property (s_riseFire
      |=> risingEvent && !riseArmed ##1 !risingEvent) else $error("rising event not single");
   chk_rise_arm: assert property (risingEvent |-> $past(riseArmed) && $past(eval))
      else $error("rising event while disarmed");
   chk_rearm_fall: assert property (eval && !riseArmed && next_meas < fallThr
      |=> riseArmed) else $error("rising path not re-armed");
   chk_fall_mirror: assert property (fallingEvent
      |-> $past(fallArmed) && $past(next_meas) < $past(fallThr) && !fallArmed)
      else $error("falling event without cause");
   chk_alarm_type: assert property (alarmType == lstm_pkg::LSTM_ALARM_FALLING
      |=> !risingEvent) else $error("rising event in falling-only mode");
   chk_sticky_set: assert property (risingEvent |=> riseFlag)
      else $error("rising flag not set");
endmodule

/* File: bench/lstm_line_model.sv */
// Line-side traffic source feeding the statistics block
`timescale 1ns/1ps
module lstm_line_model (
   input  wire logic           clk,
   output lstm_pkg::lstm_rx_t  rxEv,
   output lstm_pkg::lstm_tx_t  txEv,
   output lstm_pkg::lstm_gfp_t gfpEv
);
   initial begin
      rxEv = '0;
      txEv = '0;
      gfpEv = '0;
   end
   // Holds one pattern for n cycles; idle shows inverted stale octets
   task automatic send(input lstm_pkg::lstm_rx_t r, input lstm_pkg::lstm_tx_t t,
                       input lstm_pkg::lstm_gfp_t g, input int n);
      repeat (n) begin
         @(posedge clk);
         rxEv <= r;
         txEv <= t;
         gfpEv <= g;
      end
      @(posedge clk);
      rxEv <= '{octets: ~r.octets, default: 1'b0};
      txEv <= '{octets: ~t.octets, default: 1'b0};
      gfpEv <= '{inFrame: g.inFrame, default: 1'b0};
   endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the link statistics monitor
`timescale 1ns/1ps
`include "lstm_map.svh"
module testbench;
   logic                clk;
   logic                resetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic [11:0]         paddr;
   logic [31:0]         pwdata;
   logic                pready;
   logic [31:0]         prdata;
   logic                pslverr;
   lstm_pkg::lstm_rx_t  rxEv;
   lstm_pkg::lstm_tx_t  txEv;
   lstm_pkg::lstm_gfp_t gfpEv;
   logic                risingEvent;
   logic                fallingEvent;
   logic [31:0]         rd;
   logic                err;
   int                  miscompares = 0;
   int                  nChecks = 0;
   int                  riseCnt = 0;
   int                  fallCnt = 0;
   int                  cycles = 0;
   logic [31:0]         expCnt [18] = '{32'h1, 32'h1, 32'h17FA, 32'h2, 32'h5, 32'h4,
      32'h2, 32'h3, 32'h2, 32'h3, 32'h3, 32'h2, 32'h1, 32'h2, 32'h3, 32'h2, 32'h4, 32'h5};
   logic [5:0]          gfpBit [5] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02};

   link_stats_monitor #(.TICKS_SEC(32'h0000000A)) i_dut (.clk(clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .rxEv(rxEv), .txEv(txEv),
      .gfpEv(gfpEv), .risingEvent(risingEvent), .fallingEvent(fallingEvent));
   lstm_line_model i_line (.clk(clk), .rxEv(rxEv), .txEv(txEv), .gfpEv(gfpEv));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (risingEvent === 1'b1) begin
         riseCnt <= riseCnt + 1;
      end
      if (fallingEvent === 1'b1) begin
         fallCnt <= fallCnt + 1;
      end
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready with a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         t++;
      end while (pready !== 1'b1 && t < 16);
      if (t >= 16) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, pready, 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input logic eErr);
      apb(1'b0, a, 32'h0);
      chkWord(rd, exp);
      chkWord({31'h0, err}, {31'h0, eErr});
   endtask

   task automatic rxFrame(input logic [15:0] len, input logic bad, input logic wf);
      i_line.send('{frameDone: 1'b1, octets: len, fcsBad: bad, wellFormed: wf,
                    default: 1'b0}, '0, '0, 1);
   endtask

   task automatic txFrame(input logic [15:0] len);
      i_line.send('0, '{frameDone: 1'b1, octets: len, default: 1'b0}, '0, 1);
   endtask

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rdChk(`LSTM_CTRL, 32'h0, 1'b0);
      rdChk(`LSTM_TX_MIN_LEN, 32'h40, 1'b0);
      rdChk(`LSTM_PERIOD, 32'hF, 1'b0);
      rdChk(`LSTM_MON_STATUS, 32'h4, 1'b0);
      rdChk(12'h024, 32'h0, 1'b1);
      apb(1'b1, `LSTM_CNT_BASE, 32'h5);
      chkWord({31'h0, err}, 32'h0);
      $display("test registers done");
      rxFrame(16'h05EE, 1'b0, 1'b1);
      rxFrame(16'h05EF, 1'b0, 1'b1);
      rxFrame(16'h05EF, 1'b1, 1'b0);
      rxFrame(16'h05EE, 1'b1, 1'b0);
      rxFrame(16'h0040, 1'b1, 1'b1);
      i_line.send('{codeWord: 1'b1, default: 1'b0},
                  '{lineCodeViol: 1'b1, hdlcCrcErr: 1'b1, default: 1'b0}, '0, 3);
      i_line.send('{lineCodeViol: 1'b1, hdlcCrcErr: 1'b1, default: 1'b0},
                  '{codeWord: 1'b1, default: 1'b0}, '0, 2);
      txFrame(16'h003F);
      txFrame(16'h0040);
      apb(1'b1, `LSTM_TX_MIN_LEN, 32'h64);
      txFrame(16'h0063);
      txFrame(16'h0064);
      for (int k = 0; k < 5; k++) begin
         i_line.send('0, '0, gfpBit[k], k + 1);
      end
      repeat (2) begin
         i_line.send('0, '0, '{inFrame: 1'b1, default: 1'b0}, 3);
         i_line.send('0, '0, '0, 1);
      end
      for (int i = 0; i < 18; i++) begin
         rdChk(12'(`LSTM_CNT_BASE + 4 * i), expCnt[i], 1'b0);
         rdChk(`LSTM_CNT_HIGH, 32'h0, 1'b0);
      end
      $display("test counters done");
      apb(1'b1, `LSTM_RISE_THR, 32'h3);
      apb(1'b1, `LSTM_FALL_THR, 32'h1);
      rdChk(`LSTM_RISE_THR, 32'h3, 1'b0);
      rdChk(`LSTM_FALL_THR, 32'h1, 1'b0);
      apb(1'b1, `LSTM_CTRL, 32'h1E4);
      repeat (3) rxFrame(16'h0040, 1'b0, 1'b1);
      repeat (10) @(posedge clk);
      chkWord(32'(riseCnt), 32'h1);
      chkWord(32'(fallCnt), 32'h0);
      rdChk(`LSTM_MEASURED, 32'h8, 1'b0);
      apb(1'b1, `LSTM_PERIOD, 32'h1);
      apb(1'b1, `LSTM_CTRL, 32'h164);
      repeat (60) @(posedge clk);
      chkWord(32'(fallCnt), 32'h1);
      rdChk(`LSTM_MON_STATUS, 32'h7, 1'b0);
      rdChk(`LSTM_MEASURED, 32'h0, 1'b0);
      apb(1'b1, `LSTM_MON_STATUS, 32'h3);
      rdChk(`LSTM_MON_STATUS, 32'h4, 1'b0);
      i_line.send('{frameDone: 1'b1, octets: 16'h0040, default: 1'b0}, '0, '0, 25);
      repeat (30) @(posedge clk);
      chkWord(32'(riseCnt), 32'h2);
      chkWord(32'(fallCnt), 32'h2);
      // Falling-only mode: rising crossing consumed silently
      apb(1'b1, `LSTM_MON_STATUS, 32'h3);
      apb(1'b1, `LSTM_CTRL, 32'h144);
      i_line.send('{frameDone: 1'b1, octets: 16'h0040, default: 1'b0}, '0, '0, 25);
      repeat (30) @(posedge clk);
      chkWord(32'(riseCnt), 32'h2);
      chkWord(32'(fallCnt), 32'h3);
      rdChk(`LSTM_MON_STATUS, 32'h6, 1'b0);
      // Rising-only mode: falling crossing consumed silently
      apb(1'b1, `LSTM_CTRL, 32'h124);
      i_line.send('{frameDone: 1'b1, octets: 16'h0040, default: 1'b0}, '0, '0, 25);
      repeat (30) @(posedge clk);
      chkWord(32'(riseCnt), 32'h3);
      chkWord(32'(fallCnt), 32'h3);
      rdChk(`LSTM_MON_STATUS, 32'h7, 1'b0);
      $display("test monitor done");
      test_done();
   end
endmodule
